// ---- hw/ifeb_cfg.svh ----
`ifndef IFEB_CFG_SVH
`define IFEB_CFG_SVH

// Register byte offsets on the APB
`define IFEB_OFF_CTL 12'h000
`define IFEB_OFF_PE1 12'h004
`define IFEB_OFF_PE2 12'h008
`define IFEB_OFF_PF1 12'h00C
`define IFEB_OFF_PF2 12'h010
`define IFEB_OFF_OPT 12'h014
`define IFEB_OFF_PCE 12'h018

// Reset values
`define IFEB_RST_CTL 8'h00
`define IFEB_RST_PE1 8'h00
`define IFEB_RST_PE2 8'h00
`define IFEB_RST_PF1 8'h00
`define IFEB_RST_PF2 8'h00
`define IFEB_RST_OPT 8'h00
`define IFEB_RST_PCE 8'h00

// Interrupt control fields
`define IFEB_CTL_GIE 7
`define IFEB_CTL_PERIPHERAL_GROUP_ENABLE 6
`define IFEB_CTL_T0EN 5
`define IFEB_CTL_EXTEN 4
`define IFEB_CTL_PCEN 3
`define IFEB_CTL_T0FL 2
`define IFEB_CTL_EXTFL 1
`define IFEB_CTL_PCFL 0

// Peripheral flag one fields
`define IFEB_PF1_TX 7
`define IFEB_PF1_RX 6
`define IFEB_PF1_COLL 5
`define IFEB_PF1_SYNC 4
`define IFEB_PF1_CC2 3
`define IFEB_PF1_CC1 2
`define IFEB_PF1_T2 1
`define IFEB_PF1_T1 0

// Peripheral flag two fields
`define IFEB_PF2_DESATURATION_DETECT 7
`define IFEB_PF2_CONV 6
`define IFEB_PF2_GAP 5
`define IFEB_PF2_OTEMP 4
`define IFEB_PF2_OUTOV 3
`define IFEB_PF2_DRUV 2
`define IFEB_PF2_INOV 1
`define IFEB_PF2_INUV 0

// Option fields
`define IFEB_OPT_EDGE 0
`define IFEB_OPT_OOV_R 1
`define IFEB_OPT_OOV_F 2
`define IFEB_OPT_IOV_R 3
`define IFEB_OPT_IOV_F 4
`define IFEB_OPT_IUV_R 5
`define IFEB_OPT_IUV_F 6

// Synchroniser vector layout
`define IFEB_SYN_W 12
`define IFEB_SYN_EXT 8
`define IFEB_SYN_OOV 9
`define IFEB_SYN_IOV 10
`define IFEB_SYN_IUV 11

`endif

// ---- hw/ifeb_pkg.sv ----
package ifeb_pkg;

    typedef enum logic [2:0] {
        IFEB_R_CTL = 3'h0,
        IFEB_R_PE1 = 3'h1,
        IFEB_R_PE2 = 3'h3,
        IFEB_R_PF1 = 3'h2,
        IFEB_R_PF2 = 3'h6,
        IFEB_R_OPT = 3'h7,
        IFEB_R_PCE = 3'h5,
        IFEB_R_NONE = 3'h4
    } ifeb_reg_t;

    // Same-clock event pulses and buffer levels from the peripherals
    typedef struct packed {
        logic timer0_roll;
        logic timer1_roll;
        logic timer2_match;
        logic capcmp1_hit;
        logic capcmp2_hit;
        logic sync_port_evt;
        logic collision_evt;
        logic conv_done;
        logic overtemp_evt;
        logic drive_uv_evt;
        logic desaturation_detect_evt;
        logic tx_buf_empty;
        logic rx_buf_full;
    } ifeb_evt_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] pe1;
        logic [7:0] pe2;
        logic [7:0] pf1;
        logic [7:0] pf2;
        logic [7:0] opt;
        logic [7:0] pce;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [11:0] s3;
        logic [11:0] filt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } ifeb_state_t;

endpackage : ifeb_pkg

// ---- hw/ifeb_bank.sv ----
// What this block does
// - Global enable gates every request to core
// - Peripheral requests also need group enable
// - Flags set regardless of interrupt enables; the pin change flag needs its pin enabled in PCE
// - Core-source enables at control bits 5..3
// - Timer0 rollover sets flag, software clears
// - External pin flag sticky until cleared
// - Enabled pin change sets change flag
// - Peripheral enable one layout, reset zero
// - Peripheral enable two layout, bit5 zero
// - Transmit flag follows empty transmit buffer
// - Receive flag follows full receive buffer
// - Timer2 period match sets sticky flag
// - Timer1 rollover sets sticky flag
// - Capture, collision and port event flags
// - Conversion complete sets converter flag
// - Output overvoltage flag on selected edge
// - Input overvoltage flag on selected edge
// - Input undervoltage flag on selected edge
// - Overtemperature and drive undervoltage flags
// - Desaturation event sets its flag
// - Taken interrupt clears global enable
// - External pin edge chosen by option
// - Any reset clears global enable
//
// Chosen here: the placing of the registers and register access over APB.
`include "ifeb_cfg.svh"

module ifeb_bank
    import ifeb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ifeb_evt_t periph_evt,
    input wire logic [7:0] change_pins,
    input wire logic ext_irq_pin,
    input wire logic out_overvolt_in,
    input wire logic in_overvolt_in,
    input wire logic in_undervolt_in,
    input wire logic irq_taken,
    output logic irq_req
);

    function automatic ifeb_reg_t ifeb_decode(input logic [11:0] a);
        ifeb_reg_t r;
        r = IFEB_R_NONE;
        if (a == `IFEB_OFF_CTL) begin
            r = IFEB_R_CTL;
        end else if (a == `IFEB_OFF_PE1) begin
            r = IFEB_R_PE1;
        end else if (a == `IFEB_OFF_PE2) begin
            r = IFEB_R_PE2;
        end else if (a == `IFEB_OFF_PF1) begin
            r = IFEB_R_PF1;
        end else if (a == `IFEB_OFF_PF2) begin
            r = IFEB_R_PF2;
        end else if (a == `IFEB_OFF_OPT) begin
            r = IFEB_R_OPT;
        end else if (a == `IFEB_OFF_PCE) begin
            r = IFEB_R_PCE;
        end
        return r;
    endfunction : ifeb_decode

    ifeb_state_t q;
    ifeb_state_t d;
    ifeb_reg_t sel;
    logic access;
    logic commit;
    logic wr;
    logic [11:0] pins;
    logic [11:0] agree;
    logic [11:0] chg;
    logic [11:0] rise;
    logic [11:0] fall;
    logic [7:0] ctl_set;
    logic [7:0] pf1_set;
    logic [7:0] pf2_set;
    logic [7:0] wbyte;
    logic core_req;
    logic periph_req;

    assign pins = {in_undervolt_in, in_overvolt_in, out_overvolt_in,
                   ext_irq_pin, change_pins};

    always_comb begin
        d = q;
        sel = ifeb_decode(paddr);
        wbyte = pwdata[7:0];
        // One wait state: pready rises on the second access cycle
        access = psel & penable & ~q.pready;
        commit = psel & penable & q.pready;
        wr = commit & pwrite;
        d.pready = access;
        d.pslverr = access & (sel == IFEB_R_NONE);
        if (access & ~pwrite) begin
            case (sel)
                IFEB_R_CTL: d.prdata = {24'h000000, q.ctl};
                IFEB_R_PE1: d.prdata = {24'h000000, q.pe1};
                IFEB_R_PE2: d.prdata = {24'h000000, q.pe2};
                IFEB_R_PF1: d.prdata = {24'h000000, q.pf1};
                IFEB_R_PF2: d.prdata = {24'h000000, q.pf2};
                IFEB_R_OPT: d.prdata = {24'h000000, q.opt};
                IFEB_R_PCE: d.prdata = {24'h000000, q.pce};
                default: d.prdata = 32'h00000000;
            endcase
        end else if (commit) begin
            d.prdata = 32'h00000000;
        end

        // Three stages; a level counts once stages two and three agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.filt = (q.filt & ~agree) | (q.s3 & agree);
        chg = d.filt ^ q.filt;
        rise = chg & d.filt;
        fall = chg & ~d.filt;

        ctl_set = 8'h00;
        pf1_set = 8'h00;
        pf2_set = 8'h00;
        ctl_set[`IFEB_CTL_T0FL] = periph_evt.timer0_roll;
        ctl_set[`IFEB_CTL_EXTFL] = q.opt[`IFEB_OPT_EDGE] ?
            rise[`IFEB_SYN_EXT] : fall[`IFEB_SYN_EXT];
        ctl_set[`IFEB_CTL_PCFL] = |(chg[7:0] & q.pce);
        pf1_set[`IFEB_PF1_COLL] = periph_evt.collision_evt;
        pf1_set[`IFEB_PF1_SYNC] = periph_evt.sync_port_evt;
        pf1_set[`IFEB_PF1_CC2] = periph_evt.capcmp2_hit;
        pf1_set[`IFEB_PF1_CC1] = periph_evt.capcmp1_hit;
        pf1_set[`IFEB_PF1_T2] = periph_evt.timer2_match;
        pf1_set[`IFEB_PF1_T1] = periph_evt.timer1_roll;
        pf2_set[`IFEB_PF2_DESATURATION_DETECT] = periph_evt.desaturation_detect_evt;
        pf2_set[`IFEB_PF2_CONV] = periph_evt.conv_done;
        pf2_set[`IFEB_PF2_OTEMP] = periph_evt.overtemp_evt;
        pf2_set[`IFEB_PF2_DRUV] = periph_evt.drive_uv_evt;
        pf2_set[`IFEB_PF2_OUTOV] =
            (q.opt[`IFEB_OPT_OOV_R] & rise[`IFEB_SYN_OOV]) |
            (q.opt[`IFEB_OPT_OOV_F] & fall[`IFEB_SYN_OOV]);
        pf2_set[`IFEB_PF2_INOV] =
            (q.opt[`IFEB_OPT_IOV_R] & rise[`IFEB_SYN_IOV]) |
            (q.opt[`IFEB_OPT_IOV_F] & fall[`IFEB_SYN_IOV]);
        pf2_set[`IFEB_PF2_INUV] =
            (q.opt[`IFEB_OPT_IUV_R] & rise[`IFEB_SYN_IUV]) |
            (q.opt[`IFEB_OPT_IUV_F] & fall[`IFEB_SYN_IUV]);

        if (wr && sel == IFEB_R_CTL) begin
            d.ctl = wbyte;
        end
        if (wr && sel == IFEB_R_PE1) begin
            d.pe1 = wbyte;
        end
        // Enable two, gap bit held low
        if (wr && sel == IFEB_R_PE2) begin
            d.pe2 = wbyte;
        end
        d.pe2[`IFEB_PF2_GAP] = 1'b0;
        if (wr && sel == IFEB_R_PF1) begin
            d.pf1 = wbyte;
        end
        if (wr && sel == IFEB_R_PF2) begin
            d.pf2 = wbyte;
        end
        if (wr && sel == IFEB_R_OPT) begin
            d.opt = {1'b0, wbyte[6:0]};
        end
        if (wr && sel == IFEB_R_PCE) begin
            d.pce = wbyte;
        end

        // Sticky flags; a set wins over a clear in the same cycle
        d.ctl = d.ctl | ctl_set;
        d.pf1 = d.pf1 | pf1_set;
        d.pf2 = d.pf2 | pf2_set;
        d.pf2[`IFEB_PF2_GAP] = 1'b0;
        // Transmit flag is the buffer level, not writable
        d.pf1[`IFEB_PF1_TX] = periph_evt.tx_buf_empty;
        // Receive flag is the buffer level, not writable
        d.pf1[`IFEB_PF1_RX] = periph_evt.rx_buf_full;
        // Entry to service beats a write setting the bit
        if (irq_taken) begin
            d.ctl[`IFEB_CTL_GIE] = 1'b0;
        end

        // A stale flag raises a request as soon as it is enabled
        core_req = |(d.ctl[5:3] & d.ctl[2:0]);
        periph_req = d.ctl[`IFEB_CTL_PERIPHERAL_GROUP_ENABLE] &
            (|(d.pe1 & d.pf1) | |(d.pe2 & d.pf2));
        d.irq = d.ctl[`IFEB_CTL_GIE] & (core_req | periph_req);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.ctl <= `IFEB_RST_CTL;
            q.pe1 <= `IFEB_RST_PE1;
            q.pe2 <= `IFEB_RST_PE2;
            q.pf1 <= `IFEB_RST_PF1;
            q.pf2 <= `IFEB_RST_PF2;
            q.opt <= `IFEB_RST_OPT;
            q.pce <= `IFEB_RST_PCE;
            q.s1 <= 12'h000;
            q.s2 <= 12'h000;
            q.s3 <= 12'h000;
            q.filt <= 12'h000;
            q.prdata <= 32'h00000000;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.irq <= 1'b0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq_req = q.irq;

endmodule : ifeb_bank

// ---- test/ifeb_bank_sva.sv ----
module ifeb_bank_sva
    import ifeb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ifeb_evt_t periph_evt,
    input wire logic irq_taken,
    input wire logic irq_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_acc;
        clk_en && psel && penable && pready;
    endsequence
    sequence s_rd;
        s_acc ##0 !pwrite;
    endsequence
    sequence s_gie_off;
        s_acc ##0 (pwrite && paddr == 12'h000 && !pwdata[7]);
    endsequence
    property p_wait;
        clk_en && psel && penable && !pready |=> pready;
    endproperty
    property p_unm;
        s_acc ##0 (paddr > 12'h018) |-> pslverr;
    endproperty
    property p_gie;
        s_gie_off |=> !irq_req;
    endproperty
    property p_take;
        clk_en && irq_taken |=> !irq_req;
    endproperty
    property p_rst;
        $rose(presetn) |-> !irq_req && !pready;
    endproperty
    property p_gap;
        s_rd ##0 (paddr == 12'h008 || paddr == 12'h010) |-> !prdata[5];
    endproperty
    // Timer0 pulse four edges back, no write in between
    property p_t0;
        s_rd ##0 (paddr == 12'h000 && !$past(pready, 3)
            && $past(presetn, 4) && $past(periph_evt.timer0_roll, 4))
            |-> prdata[2];
    endproperty
    property p_tx;
        s_rd ##0 (paddr == 12'h00C
            && $past(periph_evt.tx_buf_empty) == periph_evt.tx_buf_empty
            && $past(periph_evt.tx_buf_empty, 2) == periph_evt.tx_buf_empty)
            |-> prdata[7] == periph_evt.tx_buf_empty;
    endproperty
    a_wait: assert property (p_wait)
        else $error("no answer after one wait");
    a_unm: assert property (p_unm)
        else $error("unmapped without error");
    a_gie: assert property (p_gie)
        else $error("request with global enable off");
    a_take: assert property (p_take)
        else $error("request after take");
    a_rst: assert property (p_rst)
        else $error("output after reset");
    a_gap: assert property (p_gap)
        else $error("bit 5 not zero");
    a_t0: assert property (p_t0)
        else $error("timer0 flag missing");
    a_tx: assert property (p_tx)
        else $error("tx flag not level");
endmodule : ifeb_bank_sva

bind ifeb_bank ifeb_bank_sva u_sva (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_evt(periph_evt), .irq_taken(irq_taken),
    .irq_req(irq_req));

// ---- test/ifeb_core_model.sv ----
module ifeb_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ack_en,
    input wire logic irq_req,
    output logic irq_taken
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_taken <= 1'b0;
        end else begin
            irq_taken <= ack_en && irq_req && !irq_taken;
        end
    end
endmodule : ifeb_core_model

// ---- test/testbench.sv ----
module testbench import ifeb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, tk, ack = 1'b0, err_s;
    logic ext = 1'b0, oov = 1'b0, iov = 1'b0, iuv = 1'b0, ce = 1'b1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [7:0] pins = '0;
    ifeb_evt_t ev = '0;
    int failures = 0, comparisons = 0;
    always #50 pclk = ~pclk;
    ifeb_bank dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_evt(ev), .change_pins(pins),
        .ext_irq_pin(ext), .out_overvolt_in(oov), .in_overvolt_in(iov),
        .in_undervolt_in(iuv), .irq_taken(tk), .irq_req(irq));
    ifeb_core_model core (.pclk(pclk), .presetn(presetn), .ack_en(ack),
        .irq_req(irq), .irq_taken(tk));
    task automatic chk(input string s, input logic [31:0] e,
            input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", s, e, v);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w,
            input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            failures++;
            $display("[ERR] apb no answer at %h", a);
        end
        r = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
            input string s);
        logic [31:0] r;
        apb(a, 1'b0, 8'h00, r);
        chk(s, {24'h000000, e}, r);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask : wr
    task automatic pulse(input logic [12:0] p);
        @(posedge pclk);
        ev <= ev | p;
        @(posedge pclk);
        ev <= ev & ~p;
    endtask : pulse
    task automatic t_regs();
        for (int i = 0; i < 7; i++) begin
            rd(12'(i * 4), 8'h00, "reset value");
        end
        rd(12'h01C, 8'h00, "unmapped read");
        chk("unmapped err", 32'h1, {31'h0, err_s});
        wr(12'h004, 8'hFF);
        rd(12'h004, 8'hFF, "enable one");
        wr(12'h008, 8'hFF);
        rd(12'h008, 8'hDF, "enable two");
        wr(12'h004, 8'h00);
        wr(12'h008, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_flags();
        pulse(13'h1FFC);
        rd(12'h000, 8'h04, "timer0 flag");
        rd(12'h00C, 8'h3F, "flag one");
        rd(12'h010, 8'hD4, "flag two");
        chk("no request", 32'h0, {31'h0, irq});
        ev.tx_buf_empty <= 1'b1;
        rd(12'h00C, 8'hBF, "tx level");
        ev.tx_buf_empty <= 1'b0;
        ev.rx_buf_full <= 1'b1;
        rd(12'h00C, 8'h7F, "rx level");
        ev.rx_buf_full <= 1'b0;
        wr(12'h00C, 8'h00);
        wr(12'h010, 8'h00);
        wr(12'h000, 8'h00);
        rd(12'h00C, 8'h00, "flags cleared");
        $display("t_flags done");
    endtask : t_flags
    task automatic t_irq();
        wr(12'h004, 8'h01);
        wr(12'h000, 8'h80);
        pulse(13'h0800);
        repeat (2) @(posedge pclk);
        chk("group gate", 32'h0, {31'h0, irq});
        wr(12'h00C, 8'h00);
        wr(12'h000, 8'hC0);
        pulse(13'h0800);
        repeat (2) @(posedge pclk);
        chk("peripheral req", 32'h1, {31'h0, irq});
        ack <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("taken", 32'h0, {31'h0, irq});
        rd(12'h000, 8'h40, "global cleared");
        ack <= 1'b0;
        wr(12'h000, 8'hA0);
        pulse(13'h1000);
        repeat (2) @(posedge pclk);
        chk("core req", 32'h1, {31'h0, irq});
        wr(12'h000, 8'h24);
        @(posedge pclk);
        chk("global off", 32'h0, {31'h0, irq});
        $display("t_irq done");
    endtask : t_irq
    task automatic t_pins();
        wr(12'h000, 8'h00);
        wr(12'h014, 8'h2B);
        wr(12'h018, 8'h01);
        {ext, oov, iov, iuv} <= 4'hF;
        pins <= 8'h02;
        repeat (8) @(posedge pclk);
        rd(12'h000, 8'h02, "rise");
        rd(12'h010, 8'h0B, "comp rise");
        wr(12'h000, 8'h00);
        wr(12'h010, 8'h00);
        wr(12'h014, 8'h54);
        {ext, oov, iov, iuv} <= 4'h0;
        pins <= 8'h03;
        repeat (8) @(posedge pclk);
        rd(12'h000, 8'h03, "fall");
        rd(12'h010, 8'h0B, "comp fall");
        // Clock enable low must freeze the flags
        ce <= 1'b0;
        pulse(13'h1000);
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(12'h000, 8'h03, "frozen");
        $display("t_pins done");
    endtask : t_pins
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_flags();
        t_irq();
        t_pins();
        report_and_stop();
    end
    // Run needs about 200 cycles; allow 1000
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
endmodule : testbench
